// [bench/bbx_debug_model.sv]
// Behavioural debug monitor answering breakpoint acknowledge cycles
`timescale 1ns/10ps
module bbx_debug_model (
    // Clock and cycle
    input wire        clk,
    input wire        ackCycle,
    // Answer choice: 0 word, 1 byte port, 2 bus error, 3 sync end
    input wire [1:0]  respMode,
    input wire [15:0] respWord,
    input wire [3:0]  respDelay,
    // Terminations and returned data
    output reg        dataTransferAck,
    output reg        busErrorIn,
    output reg        peripheralValidIn,
    output reg [1:0]  asyncSizeAck,
    output reg        syncCycleEnd,
    output reg [15:0] busData
);
    reg  [3:0] waitCnt   = 4'h0;
    reg        lowByte   = 1'h0;
    wire       answering = busErrorIn | syncCycleEnd | (|asyncSizeAck);
    initial begin
        dataTransferAck   = 1'h0;
        peripheralValidIn = 1'h0;
        busErrorIn        = 1'h0;
        asyncSizeAck      = 2'h0;
        syncCycleEnd      = 1'h0;
        busData           = 16'hA5C3;
    end
    always @(posedge clk) begin
        if (ackCycle && !answering && waitCnt != respDelay) begin
            waitCnt <= waitCnt + 4'h1;
        end else if (ackCycle && !answering) begin
            waitCnt <= 4'h0;
            case (respMode)
                2'h0: begin
                    asyncSizeAck <= 2'h3;
                    busData      <= respWord;
                end
                2'h1: begin
                    asyncSizeAck <= 2'h1;
                    lowByte      <= ~lowByte;
                    busData      <= lowByte ? {respWord[7:0], ~respWord[7:0]}
                                            : {respWord[15:8], ~respWord[15:8]};
                end
                2'h2: busErrorIn <= 1'h1;
                default: begin
                    syncCycleEnd <= 1'h1;
                    busData      <= respWord;
                end
            endcase
        end else begin
            waitCnt <= 4'h0;
            // Release only once the cycle has ended
            if (!ackCycle && answering) begin
                asyncSizeAck <= 2'h0;
                busErrorIn   <= 1'h0;
                syncCycleEnd <= 1'h0;
                busData      <= ~busData;
            end
        end
    end
endmodule // bbx_debug_model

// [bench/bbx_exec_checker.sv]
// Concurrent checks on the executor's ports
`timescale 1ns/10ps
`include "bbx_exec_regs.vh"
module bbx_exec_checker (
    // Clock and reset
    input wire        clk,
    input wire        arst_n,
    // Request
    input wire        opStart,
    input wire [15:0] opWord,
    input wire [31:0] opAddr,
    input wire [31:0] bitNumValue,
    input wire [31:0] destOperand,
    input wire [4:0]  ccrIn,
    // Answer
    input wire        busy,
    input wire        opDone,
    input wire        illegalTrap,
    input wire        pcLoad,
    input wire [31:0] newPc,
    input wire        destWrite,
    input wire [31:0] destResult,
    input wire [4:0]  ccrOut,
    // Acknowledge cycle
    input wire        ackCycle,
    input wire [2:0]  busFc,
    input wire [31:0] busAddr,
    input wire        busErrorIn
);
    reg  [15:0] wordReg;
    reg  [31:0] addrReg;
    reg  [31:0] bitReg;
    reg  [31:0] destReg;
    reg  [4:0]  ccrReg;
    reg  [2:0]  numReg;
    wire        takeNow = opStart && !busy;
    wire        isShort = opWord[15:8] == `BBX_BRA_PAT && opWord[7:0] != 8'h00
                          && opWord[7:0] != 8'hFF;
    wire        isBset  = opWord[15:12] == 4'h0 && opWord[8:3] == 6'h38;
    wire        isBkpt  = opWord[15:3] == `BBX_BREAKPOINT_OP_PAT;
    // Request fields as seen at the taking edge
    always @(posedge clk) begin
        wordReg <= opWord;
        addrReg <= opAddr;
        bitReg  <= bitNumValue;
        destReg <= destOperand;
        ccrReg  <= ccrIn;
        if (takeNow)
            numReg <= opWord[2:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_bra; takeNow && isShort |=> pcLoad && opDone
        && newPc == addrReg + 32'h2 + {{24{wordReg[7]}}, wordReg[7:0]}; endproperty
    a_bra: assert property (p_bra) else $error("branch target wrong");
    property p_bra_flags; takeNow && isShort |=> ccrOut == ccrReg; endproperty
    a_bra_flags: assert property (p_bra_flags) else $error("branch changed flags");
    property p_bit_test_set_op; takeNow && isBset |=> destWrite
        && destResult == (destReg | (32'h1 << bitReg[4:0])); endproperty
    a_bit_test_set_op: assert property (p_bit_test_set_op) else $error("bit set result wrong");
    property p_zflag; takeNow && isBset |=>
        ccrOut == {ccrReg[4:3], ~destReg[bitReg[4:0]], ccrReg[1:0]}; endproperty
    a_zflag: assert property (p_zflag) else $error("bit set flags wrong");
    property p_breakpoint_op_go; takeNow && isBkpt |=> ackCycle && busy && !opDone; endproperty
    a_breakpoint_op_go: assert property (p_breakpoint_op_go) else $error("no acknowledge cycle");
    property p_addr; $rose(ackCycle) |-> busAddr == {27'h0, numReg, 2'h0}; endproperty
    a_addr: assert property (p_addr) else $error("acknowledge address wrong");
    property p_fc; ackCycle |-> busFc == `BBX_FC_CPU; endproperty
    a_fc: assert property (p_fc) else $error("function code wrong");
    property p_idle; !ackCycle |-> busFc == 3'h0 && busAddr == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("bus not idle");
    property p_bus_error_in; ackCycle && busErrorIn |-> ##[1:5] !ackCycle; endproperty
    a_bus_error_in: assert property (p_bus_error_in) else $error("bus error not ending cycle");
    property p_trap; illegalTrap |-> opDone && !pcLoad && !destWrite; endproperty
    a_trap: assert property (p_trap) else $error("trap with side effect");
endmodule // bbx_exec_checker

bind bbx_exec bbx_exec_checker i_bbx_exec_checker (.clk(clk), .arst_n(arst_n),
    .opStart(opStart), .opWord(opWord), .opAddr(opAddr), .bitNumValue(bitNumValue),
    .destOperand(destOperand), .ccrIn(ccrIn), .busy(busy), .opDone(opDone),
    .illegalTrap(illegalTrap), .pcLoad(pcLoad), .newPc(newPc), .destWrite(destWrite),
    .destResult(destResult), .ccrOut(ccrOut), .ackCycle(ackCycle), .busFc(busFc),
    .busAddr(busAddr), .busErrorIn(busErrorIn));

// [bench/bbx_exec_tb_top.sv]
// Self-checking bench for the breakpoint, branch and bit-set executor
`timescale 1ns/10ps
`include "bbx_exec_regs.vh"
module bbx_exec_tb_top;
    typedef struct {
        logic [15:0] w, e1, e2;
        logic [31:0] a, bn, d, pc, res;
        logic [4:0]  cc, ecc;
        logic        ill;
    } bbx_row_t;
    reg         clk = 1'h0, arst_n = 1'h0, opStart = 1'h0, prevAck = 1'h0, pcSeen;
    reg  [15:0] opWord = 16'h0, extWord1 = 16'h0, extWord2 = 16'h0, respWord = 16'h0;
    reg  [31:0] opAddr = 32'h0, bitNumValue = 32'h0, destOperand = 32'h0;
    reg  [4:0]  ccrIn = 5'h0;
    reg  [1:0]  respMode = 2'h0;
    reg  [3:0]  respDelay = 4'h0;
    wire        busy, opDone, illegalTrap, pcLoad, destWrite, pipeInsert, ackCycle;
    wire        dataTransferAck, busErrorIn, peripheralValidIn, syncCycleEnd;
    wire [31:0] newPc, destResult, busAddr;
    wire [15:0] pipeWord, busData;
    wire [4:0]  ccrOut;
    wire [2:0]  busFc;
    wire [1:0]  asyncSizeAck;
    integer     failCount = 0, comparisons = 0, rises = 0, i, n, base;
    bbx_row_t   rows [0:10];

    bbx_exec #(.VARIANT(`BBX_VAR_BUS32)) i_bbx_exec (.clk(clk), .arst_n(arst_n),
        .opStart(opStart), .opWord(opWord), .opAddr(opAddr), .extWord1(extWord1),
        .extWord2(extWord2), .bitNumValue(bitNumValue), .destOperand(destOperand),
        .ccrIn(ccrIn), .busy(busy), .opDone(opDone), .illegalTrap(illegalTrap),
        .pcLoad(pcLoad), .newPc(newPc), .destWrite(destWrite), .destResult(destResult),
        .ccrOut(ccrOut), .pipeInsert(pipeInsert), .pipeWord(pipeWord), .ackCycle(ackCycle),
        .busFc(busFc), .busAddr(busAddr), .dataTransferAck(dataTransferAck),
        .busErrorIn(busErrorIn), .peripheralValidIn(peripheralValidIn),
        .asyncSizeAck(asyncSizeAck), .syncCycleEnd(syncCycleEnd), .busData(busData));
    bbx_debug_model i_bbx_debug_model (.clk(clk), .ackCycle(ackCycle),
        .respMode(respMode), .respWord(respWord), .respDelay(respDelay),
        .dataTransferAck(dataTransferAck), .busErrorIn(busErrorIn),
        .peripheralValidIn(peripheralValidIn), .asyncSizeAck(asyncSizeAck),
        .syncCycleEnd(syncCycleEnd), .busData(busData));

    always #5 clk = ~clk;
    always @(posedge clk) begin
        prevAck <= ackCycle;
        if (ackCycle && !prevAck)
            rises <= rises + 1;
    end

    task chk(input string what, input [31:0] exp, input [31:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            failCount = failCount + 1;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task endSim;
        $display("comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task checkRow(input integer k);
        logic isBra;
        isBra = rows[k].w[15:8] == `BBX_BRA_PAT;
        chk("opDone", 1, opDone);
        chk("illegalTrap", rows[k].ill, illegalTrap);
        chk("pcLoad", isBra && !rows[k].ill, pcLoad);
        chk("destWrite", !isBra && !rows[k].ill, destWrite);
        if (!rows[k].ill && isBra)
            chk("newPc", rows[k].pc, newPc);
        if (!rows[k].ill && !isBra)
            chk("destResult", rows[k].res, destResult);
        if (!rows[k].ill)
            chk("ccrOut", rows[k].ecc, ccrOut);
    endtask

    task runBkpt(input [2:0] num, input [1:0] mode, input [15:0] word, input ill,
                 input integer cyc);
        @(negedge clk);
        opWord = {`BBX_BREAKPOINT_OP_PAT, num};
        opStart = 1'h1;
        respMode = mode;
        respWord = word;
        respDelay = {1'h0, num};
        ccrIn = {2'h2, num};
        base = rises;
        pcSeen = 1'h0;
        @(negedge clk);
        opWord = 16'h6010;
        @(negedge clk);
        opStart = 1'h0;
        n = 0;
        while (opDone !== 1'h1 && n < 80) begin
            pcSeen = pcSeen | pcLoad;
            @(negedge clk);
            n = n + 1;
        end
        chk("opDone", 1, opDone);
        chk("illegalTrap", ill, illegalTrap);
        chk("pipeInsert", !ill, pipeInsert);
        if (!ill)
            chk("pipeWord", word, pipeWord);
        chk("ackCycles", cyc, rises - base);
        chk("refused", 0, pcSeen);
        chk("ccrOut", {2'h2, num}, ccrOut);
        n = 0;
        while (busy !== 1'h0 && n < 20) begin
            @(negedge clk);
            n = n + 1;
        end
        $display("breakpoint %0d done", num);
    endtask

    initial begin
        rows[0]  = '{16'h6010, 0, 0, 32'h100, 0, 0, 32'h112, 0, 5'h1F, 5'h1F, 0};
        rows[1]  = '{16'h60FE, 0, 0, 32'h200, 0, 0, 32'h200, 0, 5'h0A, 5'h0A, 0};
        rows[2]  = '{16'h6000, 16'h0002, 0, 32'h300, 0, 0, 32'h304, 0, 5'h11, 5'h11, 0};
        rows[3]  = '{16'h6000, 16'h8000, 0, 32'h300, 0, 0, 32'hFFFF8302, 0, 5'h0, 5'h0, 0};
        rows[4]  = '{16'h60FF, 16'h0001, 0, 32'h400, 0, 0, 32'h10402, 0, 5'h4, 5'h4, 0};
        rows[5]  = '{16'h01C0, 0, 0, 0, 32'h21, 32'h0, 0, 32'h2, 5'h00, 5'h04, 0};
        rows[6]  = '{16'h01C0, 0, 0, 0, 32'h1F, 32'h80000000, 0, 32'h80000000, 5'h1F, 5'h1B, 0};
        rows[7]  = '{16'h08D0, 16'h000A, 0, 0, 0, 32'hF0, 0, 32'hF4, 5'h00, 5'h04, 0};
        rows[8]  = '{16'h08F8, 16'h0008, 0, 0, 0, 32'h00, 0, 32'h01, 5'h1F, 5'h1F, 0};
        rows[9]  = '{16'h08C8, 16'h0001, 0, 0, 0, 0, 0, 0, 5'h0, 5'h0, 1};
        rows[10] = '{16'h08FC, 16'h0001, 0, 0, 0, 0, 0, 0, 5'h0, 5'h0, 1};
        repeat (20) @(negedge clk);
        chk("resetBus", 0, {opDone, ackCycle, busFc, busAddr[26:0]});
        $display("reset test done");
        arst_n = 1'h1;
        repeat (3) @(negedge clk);
        for (i = 0; i <= 11; i = i + 1) begin
            @(negedge clk);
            if (i > 0)
                checkRow(i - 1);
            opStart = i < 11;
            if (i < 11) begin
                opWord = rows[i].w;
                extWord1 = rows[i].e1;
                extWord2 = rows[i].e2;
                opAddr = rows[i].a;
                bitNumValue = rows[i].bn;
                destOperand = rows[i].d;
                ccrIn = rows[i].cc;
            end
        end
        $display("table rows done");
        @(negedge clk);
        opWord = {`BBX_BREAKPOINT_OP_PAT, 3'h2};
        respDelay = 4'hF;
        opStart = 1'h1;
        @(negedge clk);
        opStart = 1'h0;
        repeat (2) @(negedge clk);
        arst_n = 1'h0;
        @(negedge clk);
        chk("resetCycle", 0, {busy, ackCycle, busAddr[29:0]});
        arst_n = 1'h1;
        repeat (3) @(negedge clk);
        $display("mid-run reset done");
        runBkpt(3'h3, 2'h0, 16'h4E71, 1'h0, 1);
        runBkpt(3'h7, 2'h1, 16'hA55A, 1'h0, 2);
        runBkpt(3'h0, 2'h3, 16'h1234, 1'h0, 1);
        runBkpt(3'h5, 2'h2, 16'h0000, 1'h1, 1);
        endSim;
    end

    initial begin
        #100000;
        failCount = failCount + 1;
        endSim;
    end
endmodule // bbx_exec_tb_top

// [hw/bbx_exec.v]
// Decode and execute of breakpoint, branch-always and bit test-and-set
`timescale 1ns/10ps
// Notes on behaviour
// - Breakpoint is 0100100001001 in bits 15..3, low three bits hold number 0-7.
// - Second-generation breakpoint cycle drives function codes high, address all low.
// - Second-generation always traps illegal after the cycle, whatever ended it.
// - First-generation runs no acknowledge cycle, traps illegal at once.
// - 32-bit-bus breakpoint number goes on address 4..2, address 1..0 zero.
// - 32-bit-bus cycle targets CPU space with address type zero.
// - Normal termination returns a word executed right after the breakpoint.
// - Byte-wide port answer forces a second cycle for the remaining byte.
// - Bus error on a 32-bit-bus cycle means no replacement; trap illegal.
// - Fourth-generation runs the cycle, then always traps illegal.
// - Branch target is opcode address plus two plus signed byte, word or long displacement.
// - Branch is 01100000 in upper byte, signed byte displacement below.
// - Displacement 00 takes next word, FF takes next two words.
// - Long displacement only on later 32-bit variants; others byte or word.
// - Branch to next instruction needs the word form, zero byte not usable.
// - Test-and-set sets Z when bit was clear, then sets bit; other flags kept.
// - Data register destination is long, bit mod 32; memory byte, bit mod 8.
// - Bit number zero is the least significant bit.
// - Dynamic form 0000 rrr 111 mode reg; data register gives bit number.
// - Static form 0000100011 mode reg; next word low byte is bit number.
// - Only data alterable destinations accepted; 111 only with 000 or 001.
// - Full-format index modes only later 32-bit; compact core base-disp only.
`include "bbx_exec_regs.vh"

module bbx_exec #(
    parameter [2:0] VARIANT = `BBX_VAR_BUS32
) (
    // Clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // Instruction request
    input  wire        opStart,
    input  wire [15:0] opWord,
    input  wire [31:0] opAddr,
    input  wire [15:0] extWord1,
    input  wire [15:0] extWord2,
    input  wire [31:0] bitNumValue,
    input  wire [31:0] destOperand,
    input  wire [4:0]  ccrIn,
    // Instruction answer
    output reg         busy,
    output reg         opDone,
    output reg         illegalTrap,
    output reg         pcLoad,
    output reg  [31:0] newPc,
    output reg         destWrite,
    output reg  [31:0] destResult,
    output reg  [4:0]  ccrOut,
    output reg         pipeInsert,
    output reg  [15:0] pipeWord,
    // Acknowledge bus cycle
    output reg         ackCycle,
    output reg  [2:0]  busFc,
    output reg  [31:0] busAddr,
    input  wire        dataTransferAck,
    input  wire        busErrorIn,
    input  wire        peripheralValidIn,
    input  wire [1:0]  asyncSizeAck,
    input  wire        syncCycleEnd,
    input  wire [15:0] busData
);

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ACK1  = 3'h1;
    localparam [2:0] ST_GAP   = 3'h2;
    localparam [2:0] ST_ACK2  = 3'h3;
    localparam [2:0] ST_CLEAR = 3'h4;

    localparam SYNC_W = 22;

    // ****************************************************************
    // Reset release and pin synchronisers
    // ****************************************************************
    reg  [1:0]        rstPipe_reg;
    wire              rstN;
    reg  [SYNC_W-1:0] syncA_reg;
    reg  [SYNC_W-1:0] syncB_reg;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe_reg <= 2'h0;
        end else begin
            rstPipe_reg <= {rstPipe_reg[0], 1'b1};
        end
    end
    assign rstN = rstPipe_reg[1];

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            syncA_reg <= {SYNC_W{1'b0}};
            syncB_reg <= {SYNC_W{1'b0}};
        end else begin
            syncA_reg <= {busData, syncCycleEnd, asyncSizeAck, peripheralValidIn,
                          busErrorIn, dataTransferAck};
            syncB_reg <= syncA_reg;
        end
    end

    wire        sDtack = syncB_reg[0];
    wire        sBerr  = syncB_reg[1];
    wire        sVpa   = syncB_reg[2];
    wire [1:0]  sSize  = syncB_reg[4:3];
    wire        sSterm = syncB_reg[5];
    wire [15:0] sData  = syncB_reg[21:6];

    // ****************************************************************
    // Variant capabilities and decode
    // ****************************************************************
    wire isBus32   = (VARIANT == `BBX_VAR_BUS32) || (VARIANT == `BBX_VAR_COMPACT);
    wire longDispOk = (VARIANT == `BBX_VAR_BUS32) || (VARIANT == `BBX_VAR_GEN4);

    // Accepts a destination mode/register with its index extension word
    function destOk;
        input [2:0]  mode;
        input [2:0]  rn;
        input [15:0] ext;
        input [2:0]  variant;
        reg          full;
        reg          indirect;
        begin
            full     = ext[`BBX_EXT_FULL_BIT];
            indirect = (ext[2:0] != 3'h0);
            destOk   = 1'b0;
            case (mode)
                `BBX_MODE_AREG: destOk = 1'b0;
                `BBX_MODE_OTHER: destOk = (rn == `BBX_REG_ABS_W) ||
                                          (rn == `BBX_REG_ABS_L);
                `BBX_MODE_INDEX: begin
                    if (!full) begin
                        destOk = 1'b1;
                    end else if (variant == `BBX_VAR_BUS32 ||
                                 variant == `BBX_VAR_GEN4) begin
                        destOk = 1'b1;
                    end else if (variant == `BBX_VAR_COMPACT) begin
                        destOk = !indirect;
                    end
                end
                default: destOk = 1'b1;
            endcase
        end
    endfunction

    wire isBkpt    = (opWord[15:3] == `BBX_BREAKPOINT_OP_PAT);
    wire isBra     = (opWord[15:8] == `BBX_BRA_PAT);
    wire isDynSet  = (opWord[15:12] == `BBX_DYN_TOP) &&
                     (opWord[8:6] == `BBX_DYN_MID) &&
                     (opWord[5:3] != `BBX_MODE_AREG);
    wire isStatSet = (opWord[15:6] == `BBX_STATIC_PAT);

    // ****************************************************************
    // Branch target
    // ****************************************************************
    reg [31:0] braDisp;

    always @* begin
        if (opWord[7:0] == `BBX_DISP_WORD) begin
            braDisp = {{16{extWord1[15]}}, extWord1};
        end else if (opWord[7:0] == `BBX_DISP_LONG && longDispOk) begin
            braDisp = {extWord1, extWord2};
        end else begin
            braDisp = {{24{opWord[7]}}, opWord[7:0]};
        end
    end

    wire [31:0] braTarget = opAddr + `BBX_PC_STEP + braDisp;

    // ****************************************************************
    // Bit test-and-set
    // ****************************************************************
    wire        setRegDest = (opWord[5:3] == `BBX_MODE_DREG);
    wire [7:0]  rawBitNum  = isStatSet ? extWord1[7:0] : bitNumValue[7:0];
    wire [4:0]  bitNum     = rawBitNum[4:0] &
                             (setRegDest ? `BBX_LONG_MASK : `BBX_BYTE_MASK);
    wire [15:0] setIndexExt = isStatSet ? extWord2 : extWord1;
    wire        staticOk   = !isStatSet || (extWord1[15:8] == 8'h00);
    wire        setLegal   = destOk(opWord[5:3], opWord[2:0], setIndexExt, VARIANT) &&
                             staticOk;
    wire [31:0] bitMask    = 32'h0000_0001 << bitNum;
    wire        bitWasSet  = |(destOperand & bitMask);
    wire [31:0] setValue   = destOperand | bitMask;

    // ****************************************************************
    // Control state machine
    // ****************************************************************
    reg [2:0]  state_reg;
    reg [2:0]  bkNum_reg;
    reg [7:0]  hiByte_reg;

    wire term32  = sSterm || (sSize != 2'h0);
    wire anyTerm = sDtack || sBerr || sVpa || term32;

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_reg   <= ST_IDLE;
            bkNum_reg   <= 3'h0;
            hiByte_reg  <= 8'h00;
            busy        <= 1'b0;
            opDone      <= 1'b0;
            illegalTrap <= 1'b0;
            pcLoad      <= 1'b0;
            newPc       <= 32'h0000_0000;
            destWrite   <= 1'b0;
            destResult  <= 32'h0000_0000;
            ccrOut      <= 5'h00;
            pipeInsert  <= 1'b0;
            pipeWord    <= 16'h0000;
            ackCycle    <= 1'b0;
            busFc       <= 3'h0;
            busAddr     <= `BBX_ADDR_ZERO;
        end else begin
            opDone      <= 1'b0;
            illegalTrap <= 1'b0;
            pcLoad      <= 1'b0;
            destWrite   <= 1'b0;
            pipeInsert  <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (opStart) begin
                        ccrOut <= ccrIn;
                        if (isBkpt) begin
                            bkNum_reg <= opWord[2:0];
                            if (VARIANT == `BBX_VAR_GEN1) begin
                                opDone      <= 1'b1;
                                illegalTrap <= 1'b1;
                            end else begin
                                busy     <= 1'b1;
                                ackCycle <= 1'b1;
                                busFc    <= `BBX_FC_CPU;
                                busAddr  <= isBus32 ?
                                            {27'h0, opWord[2:0], 2'h0} :
                                            `BBX_ADDR_ZERO;
                                state_reg <= ST_ACK1;
                            end
                        end else if (isBra) begin
                            opDone <= 1'b1;
                            pcLoad <= 1'b1;
                            newPc  <= braTarget;
                        end else if ((isDynSet || isStatSet) && setLegal) begin
                            opDone     <= 1'b1;
                            destWrite  <= 1'b1;
                            destResult <= setValue;
                            ccrOut     <= {ccrIn[4:3], !bitWasSet, ccrIn[1:0]};
                        end else begin
                            opDone      <= 1'b1;
                            illegalTrap <= 1'b1;
                        end
                    end
                end
                ST_ACK1: begin
                    if (anyTerm) begin
                        ackCycle <= 1'b0;
                        busFc    <= 3'h0;
                        busAddr  <= `BBX_ADDR_ZERO;
                        if (!isBus32) begin
                            illegalTrap <= 1'b1;
                            opDone      <= 1'b1;
                            state_reg   <= ST_CLEAR;
                        end else if (sBerr) begin
                            illegalTrap <= 1'b1;
                            opDone      <= 1'b1;
                            state_reg   <= ST_CLEAR;
                        end else if (sSize == `BBX_SIZE_BYTE && !sSterm) begin
                            hiByte_reg <= sData[15:8];
                            state_reg  <= ST_GAP;
                        end else begin
                            pipeInsert <= 1'b1;
                            pipeWord   <= sData;
                            opDone     <= 1'b1;
                            state_reg  <= ST_CLEAR;
                        end
                    end
                end
                ST_GAP: begin
                    if (!anyTerm) begin
                        ackCycle  <= 1'b1;
                        busFc     <= `BBX_FC_CPU;
                        busAddr   <= {27'h0, bkNum_reg, 2'h0};
                        state_reg <= ST_ACK2;
                    end
                end
                ST_ACK2: begin
                    if (anyTerm) begin
                        ackCycle <= 1'b0;
                        busFc    <= 3'h0;
                        busAddr  <= `BBX_ADDR_ZERO;
                        opDone   <= 1'b1;
                        if (sBerr) begin
                            illegalTrap <= 1'b1;
                        end else begin
                            pipeInsert <= 1'b1;
                            pipeWord   <= {hiByte_reg, sData[15:8]};
                        end
                        state_reg <= ST_CLEAR;
                    end
                end
                ST_CLEAR: begin
                    if (!anyTerm) begin
                        busy      <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    busy      <= 1'b0;
                    ackCycle  <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // bbx_exec

// [hw/bbx_exec_regs.vh]
// Constants for the breakpoint, branch and bit test-and-set executor
`ifndef BBX_EXEC_REGS_VH
`define BBX_EXEC_REGS_VH

// ****************************************************************
// Processor variants
// ****************************************************************
`define BBX_VAR_GEN1        3'h0
`define BBX_VAR_GEN2        3'h1
`define BBX_VAR_BUS32       3'h2
`define BBX_VAR_GEN4        3'h3
`define BBX_VAR_COMPACT     3'h4

// ****************************************************************
// Opcode patterns
// ****************************************************************
`define BBX_BREAKPOINT_OP_PAT        13'h0909
`define BBX_BRA_PAT         8'h60
`define BBX_DISP_WORD       8'h00
`define BBX_DISP_LONG       8'hFF
`define BBX_STATIC_PAT      10'h023
`define BBX_DYN_TOP         4'h0
`define BBX_DYN_MID         3'h7
`define BBX_PC_STEP         32'h0000_0002

// ****************************************************************
// Destination mode codes
// ****************************************************************
`define BBX_MODE_DREG       3'h0
`define BBX_MODE_AREG       3'h1
`define BBX_MODE_INDEX      3'h6
`define BBX_MODE_OTHER      3'h7
`define BBX_REG_ABS_W       3'h0
`define BBX_REG_ABS_L       3'h1
`define BBX_EXT_FULL_BIT    8
`define BBX_LONG_MASK       5'h1F
`define BBX_BYTE_MASK       5'h07

// ****************************************************************
// Acknowledge cycle
// ****************************************************************
`define BBX_FC_CPU          3'h7
`define BBX_ADDR_ZERO       32'h0000_0000
`define BBX_SIZE_BYTE       2'h1

`endif
